// ==== core/err_report_cfg.svh ====
// Constants for the SCSI error status reporter: error codes, field values, sizes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ERR_REPORT_CFG_SVH
`define ERR_REPORT_CFG_SVH
`define CODE_NONE          8'h00
`define CODE_UNEXP_FREE    8'h21
`define CODE_BAD_STATUS    8'h23
`define CODE_UNEXP_PHASE   8'h24
`define CODE_SENSE_TRUNC   8'h25
`define CODE_BUS_RESET     8'h27
`define CODE_ODD_RESUME    8'h2b
`define CODE_QUEUE_CLEAR   8'h31
`define CODE_TGT_STATE     8'h32
`define CODE_NO_ARB        8'h33
`define CODE_TGT_MSG       8'h34
`define CODE_TGT_ILL_MSG   8'h35
`define STATUS_GOOD        8'h00
`define STATUS_CHECK       8'h02
`define SENSE_FILL_TRUNC   8'hff
`define SENSE_FILL_ZERO    8'h00
`define SENSE_COUNT        4
`define TAG_W              4
`endif

// ==== core/err_report_pkg.sv ====
// Types for the SCSI error status reporter.
// Assumes err_report_cfg.svh is on the include path.
`include "err_report_cfg.svh"
package err_report_pkg;
    typedef struct packed {
        logic [`TAG_W-1:0] tag;
        logic [7:0]        err_code;
        logic [7:0]        scsi_status;
        logic [7:0]        msg_byte;
        logic [7:0]        err_seq;
    } status_block_t;

    typedef struct packed {
        logic              valid;
        logic [`TAG_W-1:0] tag;
        logic              pass_through;
        logic              inhibit_auto_sense_bit;
    } cmd_info_t;
endpackage : err_report_pkg

// ==== core/sense_slot.sv ====
// One selected-sense field: captures, zero-fills or truncation-fills a byte.
// Assumes control strobes come from the reporter on the same clock.
`timescale 1ns/1ps
`include "err_report_cfg.svh"
module sense_slot (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic [7:0] load_byte,
    input  wire logic       fill_zero,
    input  wire logic       fill_trunc,
    output logic            filled,
    output logic [7:0]      value
);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            value  <= `SENSE_FILL_ZERO;
            filled <= 1'b0;
        end else if (clear) begin
            value  <= `SENSE_FILL_ZERO;
            filled <= 1'b0;
        end else if (fill_zero) begin
            value  <= `SENSE_FILL_ZERO; // R04
            filled <= 1'b1;
        end else if (load) begin
            value  <= load_byte; // R03
            filled <= 1'b1;
        end else if (fill_trunc && !filled) begin
            value  <= `SENSE_FILL_TRUNC; // R06
            filled <= 1'b1;
        end
    end
endmodule : sense_slot

// ==== core/scsi_error_status_reporter.sv ====
// SCSI error classifier: turns bus events into one status block per command.
// Assumes all event inputs are one-cycle pulses from bus logic on clk_sys,
// except bus_rst_in, which is the raw SCSI RST pin and is synchronised here.
`timescale 1ns/1ps
`include "err_report_cfg.svh"
// What this block does (R15 is the host's part)
// R01: Unexpected bus free ends the active command with code 21H.
// R02: Nonzero status on pass-through reports 23H and copies status byte.
// R03: Check Condition with sense allowed fills sense fields from device bytes.
// R04: Inhibit-auto-sense bit set writes zeroes to every sense field.
// R05: Unexpected bus phase reports code 24H.
// R06: Short sense transfer reports 25H; unfilled fields get FFH.
// R07: Assert RST only after recovery fails; active and disconnected report 27H.
// R08: Reset seen on bus ends active and every disconnected command with 27H.
// R09: Odd byte count, phase change, then data resume aborts with 2BH.
// R10: Device reset or clear queue purges disconnected commands with 31H.
// R11: Target enable while on, or disable while off, rejected with 32H.
// R12: Selection without arbitration flags code 33H.
// R13: Target-mode message stores byte and sequence, reports 34H, holds bus.
// R14: Illegal target message is rejected, recorded, disconnects, reports 35H.
// R15: Host should prepare sense data after seeing 35H.
// R16: Each code is one byte in its own command's status block, once.
module scsi_error_status_reporter
    import err_report_pkg::*;
#(
    parameter int DISC_DEPTH = 8,
    parameter int SENSE_N    = `SENSE_COUNT
) (
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire cmd_info_t       active_cmd,
    input  wire logic            disc_push,
    input  wire logic [`TAG_W-1:0] disc_push_tag,
    input  wire logic            unexp_bus_free,
    input  wire logic            status_in_valid,
    input  wire logic [7:0]      status_in,
    input  wire logic            sense_byte_valid,
    input  wire logic [7:0]      sense_byte,
    input  wire logic            sense_done,
    input  wire logic            unexp_phase,
    input  wire logic            recovery_failed,
    input  wire logic            bus_rst_in,
    input  wire logic            odd_count_xfer,
    input  wire logic            phase_left,
    input  wire logic            data_resumed,
    input  wire logic            queue_clear_sent,
    input  wire logic            tgt_enable_req,
    input  wire logic            tgt_disable_req,
    input  wire logic            sel_no_arb,
    input  wire logic            tgt_msg_valid,
    input  wire logic            tgt_msg_illegal,
    input  wire logic [7:0]      tgt_msg_byte,
    input  wire logic [7:0]      tgt_err_seq,
    input  wire logic            host_resp,
    output status_block_t        blk,
    output logic                 blk_valid,
    output logic [SENSE_N*8-1:0] blk_sense,
    output logic                 bus_rst_out,
    output logic                 bus_hold,
    output logic                 msg_reject,
    output logic                 tgt_disconnect,
    output logic                 tgt_mode_on
);
    // A one-entry queue would leave the entry index zero bits wide
    if (DISC_DEPTH < 2 || DISC_DEPTH > (1 << `TAG_W) || SENSE_N < 1) begin : g_bad_cfg
        $error("Unsupported reporter parameters");
    end

    typedef enum logic [1:0] {IDLE, SENSE, PURGE} state_t;

    state_t                        state_q;
    logic [2:0]                    rst_sync_q;
    logic                          rst_seen_q;
    logic                          odd_q;
    logic                          odd_broken_q;
    logic [DISC_DEPTH-1:0]         disc_v_q;
    logic [`TAG_W-1:0]             disc_tag_q [DISC_DEPTH];
    logic [7:0]                    purge_code_q;
    logic [$clog2(SENSE_N+1)-1:0]  sense_idx_q;
    logic [7:0]                    sense_status_q;
    logic [`TAG_W-1:0]             sense_tag_q;
    logic                          sense_inhibit_q;
    logic                          sense_short_q;
    logic [SENSE_N-1:0]            slot_filled;
    logic [SENSE_N*8-1:0]          slot_value;
    logic                          slot_clear;
    logic                          fill_zero;
    logic                          fill_trunc;
    logic                          bus_reset_now;
    logic                          purge_hit;
    logic [$clog2(DISC_DEPTH)-1:0] purge_idx;

    // Reset pin: change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_sync_q <= 3'b000;
            rst_seen_q <= 1'b0;
        end else begin
            rst_sync_q <= {rst_sync_q[1:0], bus_rst_in};
            if (rst_sync_q[1] == rst_sync_q[2])
                rst_seen_q <= rst_sync_q[2];
        end
    end

    // Our own RST coming back on the pin is not a second reset
    assign bus_reset_now = (rst_sync_q[1] && rst_sync_q[2] && !rst_seen_q && !bus_rst_out) // R08
                           || (recovery_failed && !bus_rst_out); // R07

    // Last-resort bus reset, held until the pin is seen asserted
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            bus_rst_out <= 1'b0;
        else if (recovery_failed)
            bus_rst_out <= 1'b1; // R07
        else if (rst_seen_q)
            bus_rst_out <= 1'b0;
    end

    // Odd transfer tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            odd_q        <= 1'b0;
            odd_broken_q <= 1'b0;
        end else begin
            // An odd transfer in the cycle of a block still counts
            if (blk_valid) begin
                odd_q        <= 1'b0;
                odd_broken_q <= 1'b0;
            end
            if (odd_count_xfer)
                odd_q <= 1'b1;
            if (odd_q && phase_left)
                odd_broken_q <= 1'b1; // R09
        end
    end

    // Disconnected command queue
    always_comb begin
        purge_hit = 1'b0;
        purge_idx = '0;
        for (int i = DISC_DEPTH - 1; i >= 0; i--) begin
            if (disc_v_q[i]) begin
                purge_hit = 1'b1;
                purge_idx = i[$clog2(DISC_DEPTH)-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            disc_v_q <= '0;
            for (int i = 0; i < DISC_DEPTH; i++)
                disc_tag_q[i] <= '0;
        end else if (state_q == PURGE && purge_code_q != `CODE_NONE) begin
            if (purge_hit)
                disc_v_q[purge_idx] <= 1'b0; // R10
        end else if (disc_push) begin
            if (!(&disc_v_q)) begin
                disc_v_q[purge_idx_free()]   <= 1'b1;
                disc_tag_q[purge_idx_free()] <= disc_push_tag;
            end
        end
    end

    function automatic logic [$clog2(DISC_DEPTH)-1:0] purge_idx_free();
        logic [$clog2(DISC_DEPTH)-1:0] r;
        r = '0;
        for (int i = DISC_DEPTH - 1; i >= 0; i--)
            if (!disc_v_q[i])
                r = i[$clog2(DISC_DEPTH)-1:0];
        return r;
    endfunction : purge_idx_free

    // Target mode state and message handling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tgt_mode_on    <= 1'b0;
            bus_hold       <= 1'b0;
            msg_reject     <= 1'b0;
            tgt_disconnect <= 1'b0;
        end else begin
            msg_reject     <= 1'b0;
            tgt_disconnect <= 1'b0;
            if (tgt_enable_req && !tgt_mode_on)
                tgt_mode_on <= 1'b1; // R11
            else if (tgt_disable_req && tgt_mode_on)
                tgt_mode_on <= 1'b0; // R11
            if (tgt_msg_valid && tgt_mode_on && tgt_msg_illegal) begin
                msg_reject     <= 1'b1; // R14
                tgt_disconnect <= 1'b1; // R14
            end
            if (tgt_msg_valid && tgt_mode_on && !tgt_msg_illegal)
                bus_hold <= 1'b1; // R13
            else if (host_resp || tgt_msg_valid)
                bus_hold <= 1'b0; // R14
        end
    end

    assign slot_clear = (state_q == IDLE) && status_in_valid;
    assign fill_zero  = (state_q == SENSE) && sense_inhibit_q;
    assign fill_trunc = (state_q == SENSE) && sense_done && !sense_inhibit_q;

    genvar g;
    generate
        for (g = 0; g < SENSE_N; g++) begin : g_slot
            sense_slot u_slot (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .clear      (slot_clear),
                .load       (sense_byte_valid && state_q == SENSE && sense_idx_q == g),
                .load_byte  (sense_byte),
                .fill_zero  (fill_zero),
                .fill_trunc (fill_trunc),
                .filled     (slot_filled[g]),
                .value      (slot_value[g*8 +: 8])
            );
        end
    endgenerate

    // Status block emission, one block per command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q         <= IDLE;
            blk             <= '0;
            blk_valid       <= 1'b0;
            blk_sense       <= '0;
            purge_code_q    <= `CODE_NONE;
            sense_idx_q     <= '0;
            sense_status_q  <= `STATUS_GOOD;
            sense_tag_q     <= '0;
            sense_inhibit_q <= 1'b0;
            sense_short_q   <= 1'b0;
        end else begin
            blk_valid <= 1'b0;
            case (state_q)
                IDLE: begin
                    blk          <= '0;
                    blk.tag      <= active_cmd.tag;
                    blk_sense    <= '0;
                    if (bus_reset_now) begin
                        blk.err_code <= `CODE_BUS_RESET; // R07 R08
                        blk_valid    <= active_cmd.valid;
                        purge_code_q <= `CODE_BUS_RESET;
                        state_q      <= PURGE;
                    end else if (queue_clear_sent) begin
                        purge_code_q <= `CODE_QUEUE_CLEAR; // R10
                        state_q      <= PURGE;
                    end else if (data_resumed && odd_broken_q) begin
                        blk.err_code <= `CODE_ODD_RESUME; // R09
                        blk_valid    <= active_cmd.valid;
                    end else if (unexp_bus_free) begin
                        blk.err_code <= `CODE_UNEXP_FREE; // R01
                        blk_valid    <= active_cmd.valid;
                    end else if (unexp_phase) begin
                        blk.err_code <= `CODE_UNEXP_PHASE; // R05
                        blk_valid    <= active_cmd.valid;
                    end else if ((tgt_enable_req && tgt_mode_on)
                                 || (tgt_disable_req && !tgt_mode_on)) begin
                        blk.err_code <= `CODE_TGT_STATE; // R11
                        blk_valid    <= 1'b1;
                    end else if (sel_no_arb) begin
                        blk.err_code <= `CODE_NO_ARB; // R12
                        blk_valid    <= 1'b1;
                    end else if (tgt_msg_valid && tgt_mode_on) begin
                        blk.err_code <= tgt_msg_illegal ? `CODE_TGT_ILL_MSG // R14
                                                        : `CODE_TGT_MSG; // R13
                        blk.msg_byte <= tgt_msg_byte;
                        blk.err_seq  <= tgt_err_seq;
                        blk_valid    <= 1'b1;
                    end else if (status_in_valid && active_cmd.pass_through
                                 && status_in != `STATUS_GOOD) begin
                        sense_tag_q     <= active_cmd.tag;
                        sense_status_q  <= status_in; // R02
                        sense_inhibit_q <= active_cmd.inhibit_auto_sense_bit;
                        sense_idx_q     <= '0;
                        sense_short_q   <= 1'b0;
                        if (status_in == `STATUS_CHECK) begin
                            state_q <= SENSE;
                        end else begin
                            blk.err_code    <= `CODE_BAD_STATUS; // R02
                            blk.scsi_status <= status_in;
                            blk_valid       <= 1'b1;
                        end
                    end
                end
                SENSE: begin
                    if (sense_byte_valid && sense_idx_q < SENSE_N)
                        sense_idx_q <= sense_idx_q + 1'b1;
                    if (fill_trunc)
                        sense_short_q <= !(&slot_filled);
                    if (fill_zero || fill_trunc) begin
                        state_q <= PURGE;
                        purge_code_q <= `CODE_NONE;
                    end
                end
                PURGE: begin
                    if (purge_code_q == `CODE_NONE) begin
                        // Sense slots settled one cycle earlier
                        blk.tag         <= sense_tag_q;
                        blk.scsi_status <= sense_status_q;
                        // Every slot reads filled after the FFH fill; shortfall kept from then
                        blk.err_code    <= sense_short_q
                                           ? `CODE_SENSE_TRUNC // R06
                                           : `CODE_BAD_STATUS; // R16
                        blk_sense       <= slot_value;
                        blk_valid       <= 1'b1;
                        state_q         <= IDLE;
                    end else if (purge_hit) begin
                        blk          <= '0;
                        blk.tag      <= disc_tag_q[purge_idx];
                        blk.err_code <= purge_code_q; // R08 R10
                        blk_sense    <= '0;
                        blk_valid    <= 1'b1;
                    end else begin
                        state_q <= IDLE;
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end
endmodule : scsi_error_status_reporter

// ==== sim/err_report_asserts.sv ====
// Checker for the SCSI error status reporter, bound to its top-level ports.
// Assumes one clock domain, clk_sys, with the asynchronous reset rst.
`timescale 1ns/1ps
module err_report_asserts
    import err_report_pkg::*;
#(
    parameter int SENSE_N = 4
) (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 unexp_bus_free,
    input wire logic                 unexp_phase,
    input wire logic                 recovery_failed,
    input wire logic                 data_resumed,
    input wire logic                 tgt_enable_req,
    input wire logic                 tgt_disable_req,
    input wire logic                 sel_no_arb,
    input wire logic                 tgt_msg_valid,
    input wire logic                 tgt_msg_illegal,
    input wire status_block_t        blk,
    input wire logic                 blk_valid,
    input wire logic [SENSE_N*8-1:0] blk_sense,
    input wire logic                 bus_rst_out,
    input wire logic                 bus_hold,
    input wire logic                 tgt_disconnect,
    input wire logic                 tgt_mode_on
);
    logic [7:0] code_w;
    logic       tgt_req;
    // Code of the block being presented, zero when none is
    assign code_w = blk_valid ? blk.err_code : 8'h00;
    assign tgt_req = tgt_enable_req | tgt_disable_req;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    free_cause_a: assert property (code_w == 8'h21 |-> $past(unexp_bus_free))
        else $error("bus free code without its event");
    phase_cause_a: assert property (code_w == 8'h24 |-> $past(unexp_phase))
        else $error("phase code without its event");
    resume_cause_a: assert property (code_w == 8'h2b |-> $past(data_resumed))
        else $error("odd resume code without a resume");
    noarb_cause_a: assert property (code_w == 8'h33 |-> $past(sel_no_arb))
        else $error("no arbitration code without its event");
    tgt_state_a: assert property (code_w == 8'h32 |-> $past(tgt_req))
        else $error("target state code without a request");
    mode_change_a: assert property ($changed(tgt_mode_on) |-> $past(tgt_req))
        else $error("target mode changed without a request");
    msg_hold_a: assert property (code_w == 8'h34 |-> ##[0:1] bus_hold)
        else $error("bus not held after target message");
    msg_cause_a: assert property (code_w inside {8'h34, 8'h35} |-> $past(tgt_msg_valid))
        else $error("message code without a message");
    ill_disc_a: assert property ($rose(tgt_disconnect) |->
        $past(tgt_msg_illegal) || $past(tgt_msg_illegal, 2))
        else $error("disconnect without an illegal message");
    trunc_fill_a: assert property (code_w == 8'h25 |-> blk_sense[SENSE_N*8-1 -: 8] == 8'hff)
        else $error("last sense field not filled after truncation");
    bad_status_a: assert property (code_w == 8'h23 |-> blk.scsi_status != 8'h00)
        else $error("bad status code with zero status");
    rst_cause_a: assert property ($rose(bus_rst_out) |->
        $past(recovery_failed) || $past(recovery_failed, 2))
        else $error("bus reset driven without failed recovery");
    cover property (code_w == 8'h25);
    cover property (code_w == 8'h27);
    cover property (code_w == 8'h31);
    cover property (code_w == 8'h35);
endmodule : err_report_asserts

// ==== sim/scsi_peer_model.sv ====
// Far-side SCSI device model: returns a status byte and sense bytes, pulses RST.
// Assumes the bench calls its tasks; lines change at falling clk_sys edges.
`timescale 1ns/1ps
module scsi_peer_model (
    input  wire logic clk_sys,
    output logic       status_in_valid,
    output logic [7:0] status_in,
    output logic       sense_byte_valid,
    output logic [7:0] sense_byte,
    output logic       sense_done,
    output logic       bus_rst_in
);
    initial begin
        {status_in_valid, sense_byte_valid, sense_done, bus_rst_in} = 4'h0;
        status_in = 8'h00;
        sense_byte = 8'h00;
    end
    // Released data lines show the inverse of the last byte
    task automatic reply(input logic [7:0] stat, input logic sense, input int n);
        @(negedge clk_sys);
        status_in_valid = 1'b1;
        status_in = stat;
        @(negedge clk_sys);
        status_in_valid = 1'b0;
        status_in = ~stat;
        if (sense) begin
            for (int i = 0; i < n; i++) begin
                @(negedge clk_sys);
                sense_byte_valid = 1'b1;
                sense_byte = 8'ha0 + 8'(i);
                @(negedge clk_sys);
                sense_byte_valid = 1'b0;
                sense_byte = ~sense_byte;
            end
            @(negedge clk_sys);
            sense_done = 1'b1;
            @(negedge clk_sys);
            sense_done = 1'b0;
        end
    endtask : reply
    task automatic pulse_rst(input int len);
        @(negedge clk_sys);
        bus_rst_in = 1'b1;
        repeat (len) @(negedge clk_sys);
        bus_rst_in = 1'b0;
    endtask : pulse_rst
endmodule : scsi_peer_model

// ==== sim/scsi_error_status_reporter_test.sv ====
// Self-checking bench for the SCSI error status reporter.
// Assumes the reporter, its package and the peer model are compiled first.
`timescale 1ns/1ps
module scsi_error_status_reporter_test;
    import err_report_pkg::*;
    logic clk_sys, rst, mill, rej_seen, dis_seen, rso_seen;
    logic [12:0] ev;
    logic [3:0] ptag;
    logic [7:0] mbyte, mseq, stb, sbb;
    logic stv, sbv, sdone, rst_pin, blk_valid, bus_rst_out, bus_hold, msg_reject;
    logic tgt_disconnect, tgt_mode_on;
    logic [31:0] blk_sense;
    logic [15:0] mask;
    cmd_info_t act;
    status_block_t blk;
    int bad_count, comparisons, cnt;
    scsi_error_status_reporter uut (.clk_sys, .rst, .active_cmd(act), .disc_push(ev[12]),
        .disc_push_tag(ptag), .unexp_bus_free(ev[0]), .status_in_valid(stv),
        .status_in(stb), .sense_byte_valid(sbv), .sense_byte(sbb), .sense_done(sdone),
        .unexp_phase(ev[1]), .recovery_failed(ev[2]), .bus_rst_in(rst_pin),
        .odd_count_xfer(ev[3]), .phase_left(ev[4]), .data_resumed(ev[5]),
        .queue_clear_sent(ev[6]), .tgt_enable_req(ev[7]), .tgt_disable_req(ev[8]),
        .sel_no_arb(ev[9]), .tgt_msg_valid(ev[10]), .tgt_msg_illegal(mill),
        .tgt_msg_byte(mbyte), .tgt_err_seq(mseq), .host_resp(ev[11]), .blk, .blk_valid,
        .blk_sense, .bus_rst_out, .bus_hold, .msg_reject, .tgt_disconnect, .tgt_mode_on);
    scsi_peer_model peer (.clk_sys, .status_in_valid(stv), .status_in(stb),
        .sense_byte_valid(sbv), .sense_byte(sbb), .sense_done(sdone), .bus_rst_in(rst_pin));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (msg_reject === 1'b1) rej_seen = 1'b1;
        if (tgt_disconnect === 1'b1) dis_seen = 1'b1;
        if (bus_rst_out === 1'b1) rso_seen = 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected value at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic fire(input int i);
        @(negedge clk_sys);
        ev[i] = 1'b1;
        @(negedge clk_sys);
        ev[i] = 1'b0;
    endtask : fire
    task automatic wait_blk(input logic [7:0] code);
        int n;
        n = 0;
        while (blk_valid !== 1'b1 && n < 12) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(blk_valid, 1);
        chk(blk.err_code, code);
    endtask : wait_blk
    task automatic collect(input logic [7:0] code, input logic [15:0] m, input int c);
        mask = 16'h0000;
        cnt = 0;
        repeat (24) begin
            @(posedge clk_sys);
            #1;
            if (blk_valid === 1'b1) begin
                chk(blk.err_code, code);
                mask[blk.tag] = 1'b1;
                cnt++;
            end
        end
        chk(mask, m);
        chk(cnt, c);
    endtask : collect
    task automatic push(input logic [3:0] t);
        ptag = t;
        fire(12);
    endtask : push
    task automatic t_plain;
        int idx [3] = '{0, 1, 9};
        logic [7:0] codes [3] = '{8'h21, 8'h24, 8'h33};
        act = '{valid: 1'b1, tag: 4'h3, pass_through: 1'b1, inhibit_auto_sense_bit: 1'b0};
        for (int k = 0; k < 3; k++) begin
            fire(idx[k]);
            wait_blk(codes[k]);
            chk(blk.tag, 4'h3);
        end
        fire(3);
        fire(4);
        fire(5);
        wait_blk(8'h2b);
    endtask : t_plain
    task automatic t_sense;
        peer.reply(8'h08, 1'b0, 0);
        wait_blk(8'h23);
        chk(blk.scsi_status, 8'h08);
        peer.reply(8'h02, 1'b1, 4);
        wait_blk(8'h23);
        chk(blk_sense, 32'ha3a2a1a0);
        peer.reply(8'h02, 1'b1, 2);
        wait_blk(8'h25);
        chk(blk_sense, 32'hffffa1a0);
        act.inhibit_auto_sense_bit = 1'b1;
        peer.reply(8'h02, 1'b0, 0);
        wait_blk(8'h23);
        chk(blk_sense, 32'h00000000);
        act.inhibit_auto_sense_bit = 1'b0;
    endtask : t_sense
    task automatic t_target;
        chk(tgt_mode_on, 0);
        fire(7);
        repeat (3) @(negedge clk_sys);
        chk(tgt_mode_on, 1);
        fire(7);
        wait_blk(8'h32);
        fire(8);
        repeat (3) @(negedge clk_sys);
        chk(tgt_mode_on, 0);
        fire(8);
        wait_blk(8'h32);
        fire(7);
        {mill, mbyte, mseq} = {1'b0, 8'h0c, 8'h05};
        fire(10);
        wait_blk(8'h34);
        chk({blk.msg_byte, blk.err_seq}, 16'h0c05);
        repeat (4) @(negedge clk_sys);
        chk(bus_hold, 1);
        fire(11);
        repeat (3) @(negedge clk_sys);
        chk(bus_hold, 0);
        {mill, mbyte, mseq, rej_seen, dis_seen} = {1'b1, 8'h7e, 8'h09, 2'b00};
        fire(10);
        mill = 1'b0;
        wait_blk(8'h35);
        chk({blk.msg_byte, blk.err_seq}, 16'h7e09);
        repeat (3) @(negedge clk_sys);
        chk({rej_seen, dis_seen}, 2'b11);
    endtask : t_target
    task automatic t_purge;
        act.valid = 1'b0;
        push(4'h1);
        push(4'h4);
        push(4'h9);
        fire(6);
        collect(8'h31, 16'h0212, 3);
        act = '{valid: 1'b1, tag: 4'h5, pass_through: 1'b1, inhibit_auto_sense_bit: 1'b0};
        push(4'h2);
        push(4'h7);
        // The active block can come before the stimulus task returns
        fork
            peer.pulse_rst(4);
            collect(8'h27, 16'h00a4, 3);
        join
        chk(rso_seen, 0);
        act.tag = 4'h6;
        fork
            fire(2);
            collect(8'h27, 16'h0040, 1);
        join
        chk(rso_seen, 1);
    endtask : t_purge
    task automatic wrap_up;
        $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    initial begin
        {rst, ev, ptag, mbyte, mseq, mill, rej_seen, dis_seen, rso_seen} = '0;
        rst = 1'b1;
        act = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_plain();
        t_sense();
        t_target();
        t_purge();
        wrap_up();
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        bad_count++;
        wrap_up();
    end
endmodule : scsi_error_status_reporter_test
bind scsi_error_status_reporter err_report_asserts #(.SENSE_N(SENSE_N)) chk_i (.*);
